// *** logic/qdc_cmd_exec.sv ***
`timescale 1ns/1ps
module qdc_cmd_exec
  import qdc_pkg::*;
#(
  parameter int WQ_BITS    = 8,   // queue index width (wide variant)
  parameter int WQ_MAX     = 255, // highest legal queue number
  parameter int INIT_WORDS = 16   // init block length in words
) (
  input  wire logic                  i_clock,       // 10 MHz clock
  input  wire logic                  i_rst,         // sync reset, active high
  input  wire logic                  i_start,       // pulse: block ready from queue 0
  input  wire logic [15:0]           i_blk_base,    // word address of parameter block
  output qdc_mem_req_s               o_mem_req,     // shared memory access
  output logic                       o_mem_valid,   // access request
  input  wire logic                  i_mem_ack,     // access done, read data valid
  input  wire logic [15:0]           i_mem_rdata,   // read data
  input  wire logic [15:0]           i_init_word,   // stored init block word
  output logic      [4:0]            o_init_idx,    // init word index
  input  wire qdc_wq_s               i_wq,          // stored params of o_wq_sel
  output logic      [WQ_BITS-1:0]    o_wq_sel,      // selected queue
  input  wire logic [63:0]           i_act_tags,    // active tag per channel
  input  wire logic [32*7*2-1:0]     i_busy_tags,   // busy tags, channel 0 then 1
  output logic                       o_halt,        // freeze internal operations
  output logic                       o_busy,        // command executing
  output logic                       o_irq,         // pulse: completion interrupt
  output qdc_irq_s                   o_irq_info     // level and vector
);
  // command state
  qdc_state_e   state_reg, state_next;
  logic [15:0]  cmd_reg;        // command code
  logic [15:0]  opts_reg;       // command options
  logic [15:0]  vec_reg;        // vector word
  logic [15:0]  lvl_reg;        // level word
  logic [15:0]  aux_reg;        // bufa lsw / queue number / bus selection
  logic [15:0]  status_reg;     // return status
  logic [4:0]   step_reg;       // header read / write step
  logic         hdr_reg;        // in header read phase
  logic         irq_reg;        // irq pulse
  qdc_irq_s     irq_info_reg;   // irq info
  qdc_mem_req_s req_reg;        // memory request
  logic         req_valid_reg;  // memory request pending
  logic         halt_reg;       // snapshot freeze
  logic         busy_reg;       // command in progress, registered so the port has no decode glitch

  // header read list: code, options, vector, level, aux
  logic [4:0] hdr_word;
  always_comb begin
    unique case (step_reg)
      5'd0:    hdr_word = QDC_W_CODE;
      5'd1:    hdr_word = QDC_W_OPTS;
      5'd2:    hdr_word = QDC_W_VECTOR;
      5'd3:    hdr_word = QDC_W_LEVEL;
      default: hdr_word = (cmd_reg == QDC_CMD_DUMP_INIT) ? QDC_W_BUFA_LO :
                          (cmd_reg == QDC_CMD_DUMP_WQ)   ? QDC_W_WQ_NUM : QDC_W_WQ_OPT;
    endcase
  end

  // channel and queue selection
  wire logic        chan     = aux_reg[QDC_BUS_SEL_BIT];
  wire logic [31:0] act_tag  = chan ? i_act_tags[63:32] : i_act_tags[31:0];
  wire logic [32*7-1:0] busy = chan ? i_busy_tags[32*7*2-1:32*7] : i_busy_tags[32*7-1:0];
  // queue zero is the master entry and is never a dump target
  wire logic        wq_range = (aux_reg != 16'h0000) && (aux_reg <= 16'(WQ_MAX));
  wire logic        is_known = (cmd_reg == QDC_CMD_DUMP_INIT) || (cmd_reg == QDC_CMD_DUMP_WQ) ||
                               (cmd_reg == QDC_CMD_BUS_INQ);
  // queue dump needs an initialized queue in range
  wire logic        wq_bad   = (cmd_reg == QDC_CMD_DUMP_WQ) && !(wq_range && i_wq.valid);
  wire logic [15:0] exec_st  = !is_known ? QDC_ST_BAD_CMD : (wq_bad ? QDC_ST_ILL_PRM : QDC_ST_OK);

  // returned word source
  logic [15:0] src_addr;
  logic [15:0] src_data;
  logic [4:0]  src_steps;
  qdc_word_src #(
    .INIT_WORDS (INIT_WORDS)
  ) u_src (
    .i_cmd       (cmd_reg),
    .i_step      (step_reg),
    .i_buf_base  (aux_reg),
    .i_blk_base  (i_blk_base),
    .i_init_word (i_init_word),
    .i_wq        (i_wq),
    .i_act_tag   (act_tag),
    .i_busy_tags (busy),
    .o_addr      (src_addr),
    .o_data      (src_data),
    .o_steps     (src_steps)
  );

  // vector pick: error low byte, normal high byte
  wire logic [7:0] vec_pick = (status_reg != QDC_ST_OK) ? vec_reg[7:0] : vec_reg[15:8];
  wire logic       irq_en   = opts_reg[QDC_OPT_IRQ_EN];
  wire logic       data_ok  = (status_reg == QDC_ST_OK);
  wire logic       last     = (step_reg == src_steps);  // step after data is status word

  // next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      QDC_IDLE:    if (i_start) state_next = QDC_RD_HDR;
      QDC_RD_HDR:  state_next = QDC_RD_WAIT;
      QDC_RD_WAIT: if (i_mem_ack) state_next = (step_reg == 5'd4) ? QDC_EXEC : QDC_RD_HDR;
      QDC_EXEC:    state_next = QDC_WR;
      // an error skips the data words: the status write is the only one
      QDC_WR:      if (i_mem_ack && (last || !data_ok)) state_next = QDC_DONE;
      QDC_DONE:    state_next = QDC_IDLE;
    endcase
  end

  // state, step and busy
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      // reset drops any command in flight without completion
      state_reg <= QDC_IDLE;
      step_reg  <= 5'd0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      // busy follows the state one-for-one, taken from the next state
      busy_reg  <= (state_next != QDC_IDLE);
      // step restarts for header reads and again for write-back
      if (state_reg == QDC_IDLE || state_reg == QDC_EXEC) step_reg <= 5'd0;
      else if (i_mem_ack && state_next != QDC_EXEC) step_reg <= step_reg + 5'd1;
    end
  end

  // header words as they arrive
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cmd_reg <= 16'h0000;
      opts_reg <= 16'h0000;
      vec_reg <= 16'h0000;
      lvl_reg <= 16'h0000;
      aux_reg <= 16'h0000;
    end else if (state_reg == QDC_RD_WAIT && i_mem_ack) begin
      // read data stands only in the ack cycle, so take it there
      unique case (step_reg)
        5'd0:    cmd_reg  <= i_mem_rdata;
        5'd1:    opts_reg <= i_mem_rdata;
        5'd2:    vec_reg  <= i_mem_rdata;
        5'd3:    lvl_reg  <= i_mem_rdata;
        default: aux_reg  <= i_mem_rdata;
      endcase
    end
  end

  // status and snapshot freeze
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      status_reg <= QDC_ST_OK;
      halt_reg   <= 1'b0;
    end else begin
      // status fixed once at decode, later writes only copy it
      if (state_reg == QDC_EXEC) status_reg <= exec_st;
      // bus inquiry freeze from decode until status is posted
      if (state_reg == QDC_EXEC) halt_reg <= (cmd_reg == QDC_CMD_BUS_INQ);
      else if (state_reg == QDC_DONE || state_reg == QDC_IDLE) halt_reg <= 1'b0;
    end
  end

  // memory request: reads of header, then data words, status last
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      req_reg       <= '0;
      req_valid_reg <= 1'b0;
    end else if (state_reg == QDC_RD_HDR) begin
      // header read for the current step
      req_reg       <= '{wr: 1'b0, addr: i_blk_base + {11'h000, hdr_word}, data: 16'h0000};
      req_valid_reg <= 1'b1;
    end else if (state_reg == QDC_WR && !req_valid_reg) begin
      // word 0xF overwritten by busy data on inquiry
      // status goes last so the host never sees a half-filled block
      if (last || !data_ok)
        req_reg <= '{wr: 1'b1, addr: i_blk_base + {11'h000, QDC_W_STATUS}, data: status_reg};
      else
        req_reg <= '{wr: 1'b1, addr: src_addr, data: src_data};
      req_valid_reg <= 1'b1;
    end else if (i_mem_ack) begin
      // host answered: drop the request for at least one cycle
      req_valid_reg <= 1'b0;
    end
  end

  // completion interrupt after the status write
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irq_reg      <= 1'b0;
      irq_info_reg <= '0;
    end else begin
      // one-cycle pulse, only when the host asked for it
      irq_reg <= (state_reg == QDC_DONE) && irq_en;
      if (state_reg == QDC_DONE) irq_info_reg <= '{level: lvl_reg[2:0], vector: vec_pick};
    end
  end

  assign o_init_idx  = step_reg;
  assign o_wq_sel    = aux_reg[WQ_BITS-1:0];
  assign o_mem_req   = req_reg;
  assign o_mem_valid = req_valid_reg;
  assign o_halt      = halt_reg;
  assign o_busy      = busy_reg;
  assign o_irq       = irq_reg;
  assign o_irq_info  = irq_info_reg;
endmodule : qdc_cmd_exec

// *** logic/qdc_pkg.sv ***
package qdc_pkg;
  // command codes
  localparam logic [15:0] QDC_CMD_DUMP_INIT = 16'h0043;  // dump initialization parameters
  localparam logic [15:0] QDC_CMD_DUMP_WQ   = 16'h0044;  // dump one work queue
  localparam logic [15:0] QDC_CMD_BUS_INQ   = 16'h0045;  // bus status inquiry
  // parameter block word offsets
  localparam logic [4:0]  QDC_W_CODE    = 5'h00;  // command code
  localparam logic [4:0]  QDC_W_OPTS    = 5'h01;  // command options
  localparam logic [4:0]  QDC_W_STATUS  = 5'h02;  // return status
  localparam logic [4:0]  QDC_W_VECTOR  = 5'h04;  // normal/error vectors
  localparam logic [4:0]  QDC_W_LEVEL   = 5'h05;  // interrupt level
  localparam logic [4:0]  QDC_W_ACT_HI  = 5'h06;  // active tag msw
  localparam logic [4:0]  QDC_W_ACT_LO  = 5'h07;  // active tag lsw
  localparam logic [4:0]  QDC_W_BUFA_HI = 5'h08;  // buffer address msw
  localparam logic [4:0]  QDC_W_BUFA_LO = 5'h09;  // buffer address lsw
  localparam logic [4:0]  QDC_W_BUSY0   = 5'h08;  // first busy tag pair
  localparam logic [4:0]  QDC_W_WQ_NUM  = 5'h0E;  // work queue number
  localparam logic [4:0]  QDC_W_WQ_OPT  = 5'h0F;  // queue options / bus selection
  localparam logic [4:0]  QDC_W_WQ_SLOT = 5'h10;  // slot count
  localparam logic [4:0]  QDC_W_WQ_TO_H = 5'h12;  // timeout msw
  localparam logic [4:0]  QDC_W_WQ_TO_L = 5'h13;  // timeout lsw
  // field positions
  localparam int QDC_OPT_IRQ_EN  = 0;  // options bit 0
  localparam int QDC_BUS_SEL_BIT = 6;  // bus selection bit 6
  localparam int QDC_BUSY_TAGS   = 7;  // busy tags per channel
  // status codes (non-zero means error)
  localparam logic [15:0] QDC_ST_OK      = 16'h0000;  // success
  localparam logic [15:0] QDC_ST_ILL_PRM = 16'h0021;  // illegal parameter, arbitrary code
  localparam logic [15:0] QDC_ST_BAD_CMD = 16'h0020;  // unknown command, arbitrary code

  typedef enum {QDC_IDLE, QDC_RD_HDR, QDC_RD_WAIT, QDC_EXEC, QDC_WR, QDC_DONE} qdc_state_e;

  // one shared-memory word access
  typedef struct packed {
    logic        wr;    // 1 write, 0 read
    logic [15:0] addr;  // word address in shared memory
    logic [15:0] data;  // write data
  } qdc_mem_req_s;

  // stored parameters of one work queue
  typedef struct packed {
    logic        valid;    // queue initialized
    logic [15:0] options;  // queue options
    logic [15:0] slots;    // number of slots
    logic [31:0] timeout;  // command timeout
  } qdc_wq_s;

  // completion interrupt request
  typedef struct packed {
    logic [2:0] level;   // request level
    logic [7:0] vector;  // vector to present
  } qdc_irq_s;
endpackage : qdc_pkg

// *** logic/qdc_word_src.sv ***
`timescale 1ns/1ps
// picks the word to write back for a given step of a command
module qdc_word_src
  import qdc_pkg::*;
#(
  parameter int INIT_WORDS = 16  // init block length in words
) (
  input  wire logic [15:0]          i_cmd,        // command code
  input  wire logic [4:0]           i_step,       // step index
  input  wire logic [15:0]          i_buf_base,   // buffer offset
  input  wire logic [15:0]          i_blk_base,   // parameter block base
  input  wire logic [15:0]          i_init_word,  // init block word at step
  input  wire qdc_wq_s              i_wq,         // selected queue
  input  wire logic [31:0]          i_act_tag,    // active tag
  input  wire logic [32*7-1:0]      i_busy_tags,  // busy tags of channel
  output logic      [15:0]          o_addr,       // word address
  output logic      [15:0]          o_data,       // word data
  output logic      [4:0]           o_steps       // number of steps
);
  // busy tag pair index and half
  wire logic [4:0]  busy_off  = i_step - 5'd2;
  wire logic [2:0]  pair      = (busy_off[3:1] == 3'h7) ? 3'h0 : busy_off[3:1];  // steps 0-1 wrap, keep inside the array
  wire logic [31:0] busy_tag  = i_busy_tags[32*pair +: 32];
  wire logic        is_init   = (i_cmd == QDC_CMD_DUMP_INIT);
  wire logic        is_wq     = (i_cmd == QDC_CMD_DUMP_WQ);
  // dump init: same layout as original init block
  wire logic [15:0] init_addr = i_buf_base + {11'h000, i_step};
  // work queue dump: options, slots, timeout msw/lsw
  wire logic [4:0]  wq_word   = (i_step == 5'd0) ? QDC_W_WQ_OPT :
                                (i_step == 5'd1) ? QDC_W_WQ_SLOT :
                                (i_step == 5'd2) ? QDC_W_WQ_TO_H : QDC_W_WQ_TO_L;
  wire logic [15:0] wq_data   = (i_step == 5'd0) ? i_wq.options :
                                (i_step == 5'd1) ? i_wq.slots :
                                (i_step == 5'd2) ? i_wq.timeout[31:16] : i_wq.timeout[15:0];
  // inquiry: active tag words 6-7, then busy pairs 8..0x15
  wire logic [4:0]  inq_word  = QDC_W_ACT_HI + i_step;
  wire logic [15:0] inq_data  = (i_step == 5'd0) ? i_act_tag[31:16] :
                                (i_step == 5'd1) ? i_act_tag[15:0] :
                                busy_off[0] ? busy_tag[15:0] : busy_tag[31:16];

  assign o_addr  = is_init ? init_addr : i_blk_base + {11'h000, (is_wq ? wq_word : inq_word)};
  assign o_data  = is_init ? i_init_word : (is_wq ? wq_data : inq_data);
  assign o_steps = is_init ? 5'(INIT_WORDS) : (is_wq ? 5'd4 : 5'd16);
endmodule : qdc_word_src

// *** tb/qdc_cmd_monitor.sv ***
`timescale 1ns/1ps
// watches the command block's own ports
module qdc_cmd_monitor
  import qdc_pkg::*;
(
  input wire logic         i_clock,     // clock
  input wire logic         i_rst,       // sync reset
  input wire logic         i_start,     // block ready
  input wire logic [15:0]  i_blk_base,  // block base
  input wire qdc_mem_req_s o_mem_req,   // memory access
  input wire logic         o_mem_valid, // access pending
  input wire logic         i_mem_ack,   // access done
  input wire logic         o_halt,      // freeze
  input wire logic         o_busy,      // executing
  input wire logic         o_irq,       // completion pulse
  input wire qdc_irq_s     o_irq_info   // level and vector
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // request must not move while the host is still answering
  AST_REQ_HOLD: assert property (o_mem_valid && !i_mem_ack |=> o_mem_valid && $stable(o_mem_req))
    else $error("memory request changed before ack");
  AST_VALID_BUSY: assert property (o_mem_valid |-> o_busy)
    else $error("memory access outside a command");
  AST_IRQ_PULSE: assert property (o_irq |=> !o_irq)
    else $error("completion pulse too long");
  AST_IRQ_LAST: assert property (o_irq |-> $past(o_busy) && !o_mem_valid)
    else $error("completion while memory still busy");
  AST_IRQ_LEVEL: assert property (o_irq |-> o_irq_info.level != 3'h0)
    else $error("completion at level zero");
  AST_HALT_BUSY: assert property (o_halt |-> o_busy)
    else $error("halt outside a command");
  AST_HALT_INQ: assert property (o_mem_valid && o_mem_req.wr && o_mem_req.addr == i_blk_base + 16'h6 |-> o_halt)
    else $error("inquiry data written without halt");
  AST_STATUS_LAST: assert property (o_mem_valid && i_mem_ack && o_mem_req.wr && o_mem_req.addr == i_blk_base + 16'h2
      |=> !o_mem_valid [*3])
    else $error("access after status write");
  AST_START_TAKEN: assert property (!o_busy && i_start |=> o_busy)
    else $error("start not taken while idle");
  // main scenarios reached
  cover property (o_irq);
  cover property ($rose(o_halt));
  cover property (o_mem_valid && !i_mem_ack [*3]);
endmodule : qdc_cmd_monitor

// *** tb/qdc_host_mem.sv ***
`timescale 1ns/1ps
// host shared memory answering the block's word accesses
module qdc_host_mem
  import qdc_pkg::*;
(
  input  wire logic         i_clock,  // clock
  input  wire logic         i_slow,   // add wait states
  input  wire qdc_mem_req_s i_req,    // access from block
  input  wire logic         i_valid,  // access pending
  output logic              o_ack,    // one-cycle answer
  output logic      [15:0]  o_rdata   // read data
);
  logic [15:0] mem [0:255];  // low address bits only, bench keeps inside
  int          wait_cnt;     // wait states spent
  initial begin
    o_ack = 1'b0;
    o_rdata = 16'h0000;
    wait_cnt = 0;
  end
  // data toggles between answers so a stale read never looks right
  always @(posedge i_clock) begin
    if (i_valid && !o_ack && wait_cnt >= (i_slow ? 3 : 0)) begin
      o_ack <= 1'b1;
      wait_cnt <= 0;
      o_rdata <= mem[i_req.addr[7:0]];
      if (i_req.wr) mem[i_req.addr[7:0]] <= i_req.data;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      wait_cnt <= i_valid ? wait_cnt + 1 : 0;
    end
  end
endmodule : qdc_host_mem

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import qdc_pkg::*;
  localparam logic [15:0] BLK = 16'h0020;  // block base
  localparam logic [15:0] BUF = 16'h0080;  // dump buffer
  typedef struct packed {
    logic [15:0] code;  // command code
    logic        opt;   // completion interrupt
    logic [15:0] aux;   // queue number or bus selection
    logic        slow;  // host wait states
    logic [15:0] st;    // expected status
  } qdc_row_s;
  logic i_clock = 1'b0, i_rst = 1'b1, i_start = 1'b0, slow = 1'b0, extra_start = 1'b0;
  logic ack, mem_valid, halt, busy, irq, halt_seen;
  logic [15:0] rdata, init_w;
  logic [4:0] init_idx;
  logic [7:0] wq_sel;
  logic [447:0] busy_t;
  logic [63:0] act = {32'hC1C1_0101, 32'hC0C0_0100};  // active tags ch1, ch0
  qdc_mem_req_s req;
  qdc_irq_s irq_info, irq_got;
  qdc_wq_s wq;
  int miscompares = 0, n_tests = 0, irq_cnt = 0;
  qdc_row_s rows [8] = '{
    '{QDC_CMD_DUMP_INIT, 1'b1, 16'h0000, 1'b0, QDC_ST_OK},
    '{QDC_CMD_DUMP_WQ, 1'b1, 16'h0001, 1'b1, QDC_ST_OK},
    '{QDC_CMD_DUMP_WQ, 1'b0, 16'h00FF, 1'b0, QDC_ST_OK},
    '{QDC_CMD_DUMP_WQ, 1'b1, 16'h0005, 1'b0, QDC_ST_ILL_PRM},
    '{QDC_CMD_DUMP_WQ, 1'b1, 16'h0000, 1'b0, QDC_ST_ILL_PRM},
    '{QDC_CMD_BUS_INQ, 1'b1, 16'h0000, 1'b1, QDC_ST_OK},
    '{QDC_CMD_BUS_INQ, 1'b1, 16'h0040, 1'b0, QDC_ST_OK},
    '{16'h0046, 1'b1, 16'h0000, 1'b0, QDC_ST_BAD_CMD}};
  // stored state behind the block: init words, queues (5 uninitialized)
  assign init_w = 16'hA500 | {11'h000, init_idx};
  assign wq = '{valid: wq_sel != 8'h05, options: {8'h00, wq_sel}, slots: {8'h00, wq_sel} + 16'h3,
                timeout: {16'h1234, 8'h00, wq_sel}};
  initial forever #50 i_clock = ~i_clock;
  qdc_cmd_exec i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_start(i_start), .i_blk_base(BLK), .o_mem_req(req),
    .o_mem_valid(mem_valid), .i_mem_ack(ack), .i_mem_rdata(rdata), .i_init_word(init_w), .o_init_idx(init_idx),
    .i_wq(wq), .o_wq_sel(wq_sel), .i_act_tags(act), .i_busy_tags(busy_t), .o_halt(halt), .o_busy(busy),
    .o_irq(irq), .o_irq_info(irq_info));
  qdc_host_mem u_host (.i_clock(i_clock), .i_slow(slow), .i_req(req), .i_valid(mem_valid), .o_ack(ack),
    .o_rdata(rdata));
  // completion and halt observers
  always @(posedge i_clock) begin
    if (irq) irq_cnt++;
    if (irq) irq_got = irq_info;
    if (halt) halt_seen = 1'b1;
  end
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_b
  // build block in host memory, start it, wait for completion
  task automatic run(input qdc_row_s r);
    int n;
    for (int a = 0; a < 22; a++) u_host.mem[BLK + 16'(a)] = 16'h0000;
    u_host.mem[BLK] = r.code;
    u_host.mem[BLK + 16'h1] = {15'h0000, r.opt};
    u_host.mem[BLK + 16'h4] = 16'h5AC3;
    u_host.mem[BLK + 16'h5] = 16'h0003;
    u_host.mem[BLK + 16'h9] = BUF;
    u_host.mem[BLK + (r.code == QDC_CMD_BUS_INQ ? 16'hF : 16'hE)] = r.aux;
    slow = r.slow;
    irq_cnt = 0;
    halt_seen = 1'b0;
    @(negedge i_clock) i_start = 1'b1;
    @(negedge i_clock) i_start = 1'b0;
    if (extra_start) begin
      repeat (4) @(negedge i_clock);
      i_start = 1'b1;
      @(negedge i_clock) i_start = 1'b0;
    end
    for (n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge i_clock);
    chk_b(busy, 1'b0);
    repeat (3) @(negedge i_clock);
  endtask : run
  task automatic check(input qdc_row_s r);
    logic [15:0] st;
    int c;
    st = u_host.mem[BLK + 16'h2];
    c = int'(r.aux[6]);
    chk_w(st, r.st);
    chk_w(16'(irq_cnt), {15'h0000, r.opt});
    chk_b(halt_seen, r.code == QDC_CMD_BUS_INQ);
    if (r.opt) chk_w({5'h00, irq_got}, {8'h03, st == QDC_ST_OK ? 8'h5A : 8'hC3});
    if (r.st == QDC_ST_OK && r.code == QDC_CMD_DUMP_INIT)
      for (int i = 0; i < 16; i++) chk_w(u_host.mem[BUF + 16'(i)], 16'hA500 | 16'(i));
    if (r.st == QDC_ST_OK && r.code == QDC_CMD_DUMP_WQ) begin
      chk_w(u_host.mem[BLK + 16'hF], r.aux);
      chk_w(u_host.mem[BLK + 16'h10], r.aux + 16'h3);
      chk_w(u_host.mem[BLK + 16'h12], 16'h1234);
      chk_w(u_host.mem[BLK + 16'h13], r.aux);
    end
    if (r.code == QDC_CMD_BUS_INQ) begin
      chk_w(u_host.mem[BLK + 16'h6], act[32*c+16 +: 16]);
      chk_w(u_host.mem[BLK + 16'h7], act[32*c +: 16]);
      for (int k = 0; k < 7; k++) begin
        chk_w(u_host.mem[BLK + 16'(8 + 2*k)], 16'hB000 | 16'(7*c + k));
        chk_w(u_host.mem[BLK + 16'(9 + 2*k)], 16'h0E00 | 16'(7*c + k));
      end
    end
  endtask : check
  task automatic final_report();
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #3000000;
    miscompares++;
    $display("Error at %0t: timeout", $time);
    final_report();
  end
  initial begin
    for (int j = 0; j < 14; j++) busy_t[32*j +: 32] = {16'hB000 | 16'(j), 16'h0E00 | 16'(j)};
    repeat (6) @(negedge i_clock);
    i_rst = 1'b0;
    @(negedge i_clock);
    chk_b(busy, 1'b0);
    chk_b(irq, 1'b0);
    foreach (rows[i]) begin
      run(rows[i]);
      check(rows[i]);
    end
    // a second start while busy must leave one completion only
    extra_start = 1'b1;
    run(rows[5]);
    check(rows[5]);
    extra_start = 1'b0;
    // reset in mid-command aborts it without completion
    fork
      run(rows[1]);
      begin
        repeat (8) @(negedge i_clock);
        i_rst = 1'b1;
        @(negedge i_clock) i_rst = 1'b0;
      end
    join
    chk_w(16'(irq_cnt), 16'h0000);
    run(rows[2]);
    check(rows[2]);
    final_report();
  end
endmodule : testbench
bind qdc_cmd_exec qdc_cmd_monitor u_mon (.i_clock(i_clock), .i_rst(i_rst), .i_start(i_start),
  .i_blk_base(i_blk_base), .o_mem_req(o_mem_req), .o_mem_valid(o_mem_valid), .i_mem_ack(i_mem_ack),
  .o_halt(o_halt), .o_busy(o_busy), .o_irq(o_irq), .o_irq_info(o_irq_info));
